// file: verilog/blu_top.sv
`timescale 1ns/1ps
module blu_top
   import blu_pkg::*;
(
   input  wire logic              CLOCK,
   input  wire logic              RST,
   input  wire logic              HSEL,
   input  wire logic [31:0]       HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output logic      [31:0]       HRDATA,
   output logic                   HREADYOUT,
   output logic                   HRESP,
   input  wire logic [IWW-1:0]    CURRENT_INSTRUCTION_WORD,
   input  wire logic [IDXW-1:0]   INDEX_SOURCE_REG,
   input  wire logic [OPW-1:0]    FIRST_OPERAND_REG,
   input  wire logic [OPW-1:0]    SECOND_OPERAND_REG,
   input  wire logic              GO_BOOLEAN,
   output logic      [OPW-1:0]    RESULT_OPERAND_REG,
   output logic                   RESULT_OPERAND_WE,
   output logic      [IDXW-1:0]   INDEX_DEST_REG,
   output logic                   INDEX_DEST_WE
);

   logic [IDXW-1:0] idx_q_r;
   logic [OPW-1:0]  xj_q_r;
   logic [OPW-1:0]  xk_q_r;
   logic            f0_r;
   logic [2:0]      m_r;
   logic [3:0]      op;
   blu_ctrl_s       c;
   logic [OPW-1:0]  xk_in;
   logic [OPW-1:0]  and_result;
   logic [OPW-1:0]  xnor_result;
   logic [OPW-1:0]  bool_n;
   logic [HIW-1:0]  fill_n;
   logic [HIW-1:0]  pack_n;
   logic [10:0]     biased;
   logic            comp_b;
   logic [9:0]      exp_cc;
   logic            sign_n;
   logic [OPW-1:0]  result_nxt;
   logic [IDXW-1:0] idx_nxt;
   logic            fire;

   logic            en_r;
   logic [CNTW-1:0] cnt_r;
   logic [3:0]      last_op_r;
   blu_dphase_s     dp_r;
   logic            stat_clr;

   // Input and control capture, every clock
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         idx_q_r <= '0;
         xj_q_r  <= '0;
         xk_q_r  <= '0;
         f0_r    <= 1'b0;
         m_r     <= 3'h0;
      end else begin
         idx_q_r <= INDEX_SOURCE_REG;
         xj_q_r  <= FIRST_OPERAND_REG;
         xk_q_r  <= SECOND_OPERAND_REG;
         f0_r    <= CURRENT_INSTRUCTION_WORD[F0_BIT];
         m_r     <= CURRENT_INSTRUCTION_WORD[M_LO+2:M_LO];
      end
   end

   assign op = {f0_r, m_r};
   assign c  = blu_decode(op);

   // Static selection network, complemented domain
   always_comb begin
      xk_in       = c.inv ? ~xk_q_r : xk_q_r;
      and_result  = xj_q_r & xk_in & {OPW{c.prod}};
      xnor_result = ~((xj_q_r & {OPW{c.xj}})
                     ^ (xk_in & {{HIW{c.xk_hi}}, {(COEF_HI+1){c.xk_lo}}}));
      bool_n      = ~and_result & xnor_result;
      fill_n      = {HIW{~(c.extend & xk_q_r[OPW-1])}};
      biased      = {~idx_q_r[10], idx_q_r[9:0]};
      comp_b      = c.gate_b & xk_q_r[OPW-1];
      pack_n      = c.gate_b ? {~comp_b, (comp_b ? biased : ~biased)}
                             : {HIW{1'b1}};
      result_nxt  = ~(bool_n & {fill_n & pack_n, {(COEF_HI+1){1'b1}}});
      exp_cc      = xk_q_r[OPW-1] ? xk_q_r[57:48] : ~xk_q_r[57:48];
      sign_n      = xk_q_r[58] ^ xk_q_r[59];
      idx_nxt     = {{(IDXW-10){~sign_n}}, ~exp_cc};
   end

   assign fire = GO_BOOLEAN && en_r;

   // Destination drive, only while the strobe stands
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         RESULT_OPERAND_WE  <= 1'b0;
         RESULT_OPERAND_REG <= '0;
      end else begin
         RESULT_OPERAND_WE <= fire;
         if (fire) begin
            RESULT_OPERAND_REG <= result_nxt;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         INDEX_DEST_WE  <= 1'b0;
         INDEX_DEST_REG <= '0;
      end else begin
         INDEX_DEST_WE <= fire && c.extend;
         if (fire && c.extend) begin
            INDEX_DEST_REG <= idx_nxt;
         end
      end
   end

   // Bus slave: zero wait, always OKAY
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         dp_r      <= '0;
         HRDATA    <= WORD_ZERO;
         HREADYOUT <= 1'b0;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         dp_r      <= '0;
         if (HSEL && HTRANS[1] && HREADY) begin
            dp_r.valid <= (HSIZE == SIZE_WORD);
            dp_r.write <= HWRITE;
            dp_r.addr  <= HADDR[7:0];
            case (HADDR[7:0])
               ADDR_CTRL: HRDATA <= {31'h0000_0000, en_r};
               ADDR_STAT: HRDATA <= {12'h000, last_op_r, cnt_r};
               default:   HRDATA <= WORD_ZERO;
            endcase
         end
      end
   end

   assign stat_clr = dp_r.valid && dp_r.write && (dp_r.addr == ADDR_STAT);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         en_r <= CTRL_RST;
      end else if (dp_r.valid && dp_r.write && (dp_r.addr == ADDR_CTRL)) begin
         en_r <= HWDATA[0];
      end
   end

   // Result counter; a strobe in the clearing cycle still counts
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cnt_r     <= '0;
         last_op_r <= 4'h0;
      end else begin
         if (stat_clr) begin
            cnt_r <= fire ? CNTW'(1) : '0;
         end else if (fire) begin
            cnt_r <= cnt_r + CNTW'(1);
         end
         if (fire) begin
            last_op_r <= op;
         end
      end
   end

   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);

   property p_we_go;
      fire |=> RESULT_OPERAND_WE ##1 (!RESULT_OPERAND_WE || $past(fire));
   endproperty
   a_we_go: assert property (p_we_go) else $error("write enable not tied to strobe");

   property p_no_we;
      !fire |=> !RESULT_OPERAND_WE && !INDEX_DEST_WE;
   endproperty
   a_no_we: assert property (p_no_we) else $error("write without strobe");

   property p_latency;
      (CURRENT_INSTRUCTION_WORD[F0_BIT] && CURRENT_INSTRUCTION_WORD[M_LO+2:M_LO] == 3'h0)
         ##1 fire |=> RESULT_OPERAND_REG == $past(FIRST_OPERAND_REG, 2);
   endproperty
   a_latency: assert property (p_latency) else $error("transmit not in two periods");

   property p_and;
      fire && op == OP_AND |=> RESULT_OPERAND_REG == $past(xj_q_r & xk_q_r);
   endproperty
   a_and: assert property (p_and) else $error("product wrong");

   property p_andn;
      fire && op == OP_ANDN |=> RESULT_OPERAND_REG == $past(xj_q_r & ~xk_q_r);
   endproperty
   a_andn: assert property (p_andn) else $error("product with inverse wrong");

   property p_or;
      fire && (op == OP_OR || op == OP_ORN) |=>
         RESULT_OPERAND_REG == $past(xj_q_r | (op[2] ? ~xk_q_r : xk_q_r));
   endproperty
   a_or: assert property (p_or) else $error("sum wrong");

   property p_xor;
      fire && (op == OP_XOR || op == OP_XORN) |=>
         RESULT_OPERAND_REG == $past(xj_q_r ^ (op[2] ? ~xk_q_r : xk_q_r));
   endproperty
   a_xor: assert property (p_xor) else $error("difference wrong");

   property p_tx;
      fire && (op == OP_TX_J || op == OP_TX_KN) |=>
         RESULT_OPERAND_REG == $past(op[2] ? ~xk_q_r : xj_q_r);
   endproperty
   a_tx: assert property (p_tx) else $error("transmit wrong");

   property p_unpack;
      fire && op == OP_UNPACK |=> INDEX_DEST_WE
         && RESULT_OPERAND_REG == $past({{HIW{xk_q_r[59]}}, xk_q_r[COEF_HI:0]})
         && INDEX_DEST_REG[9:0] == $past(xk_q_r[59] ? ~xk_q_r[57:48] : xk_q_r[57:48])
         && INDEX_DEST_REG[17:10] == {8{~$past(xk_q_r[58] ^ xk_q_r[59])}};
   endproperty
   a_unpack: assert property (p_unpack) else $error("unpack wrong");

   property p_idx_only;
      INDEX_DEST_WE |-> $past(fire && op == OP_UNPACK);
   endproperty
   a_idx_only: assert property (p_idx_only) else $error("index written outside unpack");

   property p_pack;
      fire && op == OP_PACK |=>
         RESULT_OPERAND_REG[59] == $past(xk_q_r[59])
         && RESULT_OPERAND_REG[COEF_HI:0] == $past(xk_q_r[COEF_HI:0])
         && RESULT_OPERAND_REG[58:48]
            == $past({11{xk_q_r[59]}} ^ {~idx_q_r[10], idx_q_r[9:0]});
   endproperty
   a_pack: assert property (p_pack) else $error("pack wrong");

   property p_res_hold;
      !fire |=> $stable(RESULT_OPERAND_REG);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result changed without strobe");

   property p_idx_hold;
      !(fire && c.extend) |=> $stable(INDEX_DEST_REG);
   endproperty
   a_idx_hold: assert property (p_idx_hold) else $error("index changed outside unpack");

   property p_ready;
      !RST |=> HREADYOUT && !HRESP;
   endproperty
   a_ready: assert property (p_ready) else $error("bus slave not ready or not okay");

   property p_idle;
      !(op[3] || op == OP_UNPACK || op == OP_PACK) |-> c == '0;
   endproperty
   a_idle: assert property (p_idle) else $error("path active for other opcode");

   c_and:    cover property (fire && op == OP_AND);
   c_unpack: cover property (fire && op == OP_UNPACK);
   c_pack:   cover property (fire && op == OP_PACK);
   c_b2b:    cover property (fire ##1 fire ##1 fire);

endmodule

// file: verilog/blu_pkg.sv
package blu_pkg;

   localparam int OPW      = 60;
   localparam int IDXW     = 18;
   localparam int IWW      = 15;
   localparam int COEF_HI  = 47;
   localparam int HIW      = 12;
   localparam int CNTW     = 16;
   // Position of f bit 0 and m bits 0 to 2 in the instruction word
   localparam int F0_BIT   = 12;
   localparam int M_LO     = 9;

   // Operation codes formed as {f bit 0, m}
   localparam logic [3:0] OP_UNPACK = 4'h6;
   localparam logic [3:0] OP_PACK   = 4'h7;
   localparam logic [3:0] OP_TX_J   = 4'h8;
   localparam logic [3:0] OP_AND    = 4'h9;
   localparam logic [3:0] OP_OR     = 4'hA;
   localparam logic [3:0] OP_XOR    = 4'hB;
   localparam logic [3:0] OP_TX_KN  = 4'hC;
   localparam logic [3:0] OP_ANDN   = 4'hD;
   localparam logic [3:0] OP_ORN    = 4'hE;
   localparam logic [3:0] OP_XORN   = 4'hF;

   localparam logic [7:0]  ADDR_CTRL = 8'h00;
   localparam logic [7:0]  ADDR_STAT = 8'h04;
   localparam logic [2:0]  SIZE_WORD = 3'h2;
   localparam logic        CTRL_RST  = 1'b1;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic prod;
      logic xj;
      logic xk_hi;
      logic xk_lo;
      logic inv;
      logic gate_b;
      logic extend;
   } blu_ctrl_s;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } blu_dphase_s;

   function automatic blu_ctrl_s blu_decode(input logic [3:0] op);
      blu_ctrl_s c;
      c        = '0;
      c.prod   = (op == OP_AND) || (op == OP_OR) || (op == OP_ANDN) || (op == OP_ORN);
      c.xj     = (op == OP_TX_J) || (op == OP_OR) || (op == OP_XOR) || (op == OP_ORN)
                 || (op == OP_XORN);
      c.xk_hi  = (op == OP_OR) || (op == OP_XOR) || (op == OP_TX_KN) || (op == OP_ORN)
                 || (op == OP_XORN);
      c.xk_lo  = c.xk_hi || (op == OP_UNPACK) || (op == OP_PACK);
      c.inv    = op[3] && op[2];
      c.gate_b = (op == OP_PACK);
      c.extend = (op == OP_UNPACK);
      return c;
   endfunction

endpackage

// file: testbench/blu_issue_model.sv
`timescale 1ns/1ps
module blu_issue_model
   import blu_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            req_v,
   input  wire logic [3:0]      req_op,
   input  wire logic [OPW-1:0]  req_a,
   input  wire logic [OPW-1:0]  req_b,
   input  wire logic [IDXW-1:0] req_x,
   output logic      [IWW-1:0]  word,
   output logic      [OPW-1:0]  opa,
   output logic      [OPW-1:0]  opb,
   output logic      [IDXW-1:0] opx,
   output logic                 go
);
   logic           issued_r;
   logic [IWW-1:0] iw;
   always_comb begin
      iw = '0;
      iw[F0_BIT] = req_op[3];
      iw[M_LO +: 3] = req_op[2:0];
   end
   initial begin
      word = '0;
      opa = '0;
      opb = '0;
      opx = '0;
      go = 1'b0;
      issued_r = 1'b0;
   end
   // Idle cycles invert the previous value, so every second idle cycle shows the stale operand again
   always @(posedge clock) begin
      word <= req_v ? iw : ~word;
      opa <= req_v ? req_a : ~opa;
      opb <= req_v ? req_b : ~opb;
      opx <= req_v ? req_x : ~opx;
      issued_r <= req_v;
      go <= issued_r;
   end
endmodule

// file: testbench/tb_blu_top.sv
`timescale 1ns/1ps
module tb_blu_top
   import blu_pkg::*;
;
   typedef struct packed {
      logic [3:0]      op;
      logic [OPW-1:0]  a;
      logic [OPW-1:0]  b;
      logic [IDXW-1:0] x;
      logic [OPW-1:0]  res;
   } blu_row_s;
   localparam int N = 22;
   logic            clock, rst, hsel, hwrite, hrdy, hresp, req_v, go, rwe, iwe;
   logic [31:0]     haddr, hwdata, hrdata, rd;
   logic [1:0]      htrans;
   logic [2:0]      hsize;
   logic [3:0]      req_op;
   logic [OPW-1:0]  req_a, req_b, opa, opb, res;
   logic [IDXW-1:0] req_x, opx, ixd, exp_ix;
   logic [IWW-1:0]  word;
   int              fail_count, total_checks;
   blu_row_s        rows [N];
   logic [3:0]      ops [11];
   logic [OPW-1:0]  av [2];
   logic [OPW-1:0]  bv [2];
   logic [IDXW-1:0] xv [2];

   blu_top blu_top_inst (.CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
      .HREADYOUT(hrdy), .HRESP(hresp), .CURRENT_INSTRUCTION_WORD(word), .INDEX_SOURCE_REG(opx),
      .FIRST_OPERAND_REG(opa), .SECOND_OPERAND_REG(opb), .GO_BOOLEAN(go),
      .RESULT_OPERAND_REG(res), .RESULT_OPERAND_WE(rwe), .INDEX_DEST_REG(ixd),
      .INDEX_DEST_WE(iwe));
   blu_issue_model blu_issue_model_inst (.clock(clock), .req_v(req_v), .req_op(req_op),
      .req_a(req_a), .req_b(req_b), .req_x(req_x), .word(word), .opa(opa), .opb(opb),
      .opx(opx), .go(go));

   function automatic logic [OPW-1:0] exp_res(input blu_row_s r);
      logic [10:0] e;
      e = {~r.x[10], r.x[9:0]};
      case (r.op)
         OP_TX_J:   return r.a;
         OP_AND:    return r.a & r.b;
         OP_OR:     return r.a | r.b;
         OP_XOR:    return r.a ^ r.b;
         OP_TX_KN:  return ~r.b;
         OP_ANDN:   return r.a & ~r.b;
         OP_ORN:    return r.a | ~r.b;
         OP_XORN:   return r.a ^ ~r.b;
         OP_UNPACK: return {{HIW{r.b[59]}}, r.b[COEF_HI:0]};
         OP_PACK:   return {r.b[59], {11{r.b[59]}} ^ e, r.b[COEF_HI:0]};
         default:   return '0;
      endcase
   endfunction

   function automatic logic [IDXW-1:0] exp_ixf(input logic [OPW-1:0] b);
      return {{8{~(b[58] ^ b[59])}}, {10{b[59]}} ^ b[57:48]};
   endfunction

   task automatic chk(input string nm, input logic [OPW-1:0] exp, input logic [OPW-1:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge clock); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clock); while (hrdy !== 1'b1);
      rd = hrdata;
      chk("hresp", 0, hresp);
   endtask

   // Issues rows back to back; each result is due three edges later
   task automatic run_rows(input int lo, input int hi);
      for (int i = lo; i < hi + 3; i++) begin
         req_v <= i < hi;
         if (i < hi) begin
            req_op <= rows[i].op;
            req_a <= rows[i].a;
            req_b <= rows[i].b;
            req_x <= rows[i].x;
         end
         if (i >= lo + 3) begin
            #1;
            chk("result we", 1, rwe);
            chk("result", rows[i-3].res, res);
            chk("index we", rows[i-3].op == OP_UNPACK, iwe);
            if (rows[i-3].op == OP_UNPACK) exp_ix = exp_ixf(rows[i-3].b);
            chk("index", exp_ix, ixd);
         end
         @(posedge clock);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Whole run is under 200 cycles
   initial begin
      repeat (800) @(posedge clock);
      fail_count++;
      summarize();
   end

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = SIZE_WORD;
      hwdata = '0;
      req_v = 1'b0;
      req_op = 4'h0;
      req_a = '0;
      req_b = '0;
      req_x = '0;
      exp_ix = '0;
      ops = '{4'h0, OP_TX_J, OP_AND, OP_OR, OP_XOR, OP_TX_KN, OP_ANDN, OP_ORN, OP_UNPACK,
              OP_PACK, OP_XORN};
      av = '{60'h012_3456_789A_BCDE, 60'hFED_CBA9_8765_4321};
      bv = '{60'h5A5_F0F0_3C3C_6969, 60'hC33_0FF0_A5A5_1E1E};
      xv = '{18'h0_0400, 18'h2_5B3C};
      for (int i = 0; i < N; i++) begin
         rows[i].op = ops[i % 11];
         rows[i].a = av[i / 11];
         rows[i].b = bv[i / 11];
         rows[i].x = xv[i / 11];
         rows[i].res = exp_res(rows[i]);
      end
      repeat (20) @(posedge clock);
      #1;
      chk("ready in reset", 0, hrdy);
      @(posedge clock);
      rst <= 1'b0;
      ahb(1'b0, ADDR_CTRL, WORD_ZERO);
      chk("ctrl reset", 1, rd);
      ahb(1'b0, ADDR_STAT, WORD_ZERO);
      chk("stat reset", 0, rd);
      $display("reset test done");
      run_rows(0, N);
      repeat (4) begin
         @(posedge clock);
         #1;
         chk("idle we", 0, rwe);
         chk("held result", rows[N-1].res, res);
      end
      $display("table test done");
      ahb(1'b0, ADDR_STAT, WORD_ZERO);
      chk("stat count", N, rd[15:0]);
      chk("stat opcode", ops[10], rd[19:16]);
      ahb(1'b1, ADDR_STAT, WORD_ZERO);
      ahb(1'b0, ADDR_STAT, WORD_ZERO);
      chk("stat cleared", 0, rd[15:0]);
      $display("status test done");
      ahb(1'b1, ADDR_CTRL, WORD_ZERO);
      req_v <= 1'b1;
      @(posedge clock);
      req_v <= 1'b0;
      repeat (4) begin
         @(posedge clock);
         #1;
         chk("disabled we", 0, rwe);
      end
      ahb(1'b0, ADDR_STAT, WORD_ZERO);
      chk("disabled count", 0, rd[15:0]);
      ahb(1'b1, 8'h08, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h08, WORD_ZERO);
      chk("unmapped", 0, rd);
      ahb(1'b0, ADDR_CTRL, WORD_ZERO);
      chk("ctrl off", 0, rd);
      ahb(1'b1, ADDR_CTRL, 32'h0000_0001);
      run_rows(1, 2);
      $display("enable test done");
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("reset result", 0, res);
      chk("ready in second reset", 0, hrdy);
      chk("reset index", 0, ixd);
      @(posedge clock);
      rst <= 1'b0;
      ahb(1'b0, ADDR_CTRL, WORD_ZERO);
      chk("ctrl after reset", 1, rd);
      $display("second reset test done");
      summarize();
   end
endmodule
